// >>> shared/crx_pkg.sv
// crx_pkg: constants, format tables and timing helpers for the camera link receiver.
// assumes a 25 MHz pixel clock; lane bit rate is a top-level parameter.
package crx_pkg;
  localparam int CLK_PERIOD_NS = 40;
  localparam int CLK_PERIOD_PS = 40000;
  localparam int DEF_LANE_MBPS = 800;
  localparam int CK_SETTLE_MIN_NS = 95;
  localparam int CK_SETTLE_MAX_NS = 300;
  localparam int DL_SETTLE_MIN_NS = 85;
  localparam int DL_SETTLE_MIN_UI = 6;
  localparam int DL_SETTLE_MAX_NS = 145;
  localparam int DL_SETTLE_MAX_UI = 10;
  localparam int SETTLE_W = 12;
  localparam int CNT_W = 8;
  localparam int PIX_W = 30;
  localparam int WORD_W = 64;
  localparam int TYPE_W = 6;
  localparam logic [5:0] TYPE_RST = 6'h00;
  localparam logic [5:0] TYPE_YUV420_8 = 6'h18;
  localparam logic [5:0] TYPE_YUV420_10 = 6'h19;
  localparam logic [5:0] TYPE_YUV420_LEG = 6'h1a;
  localparam logic [5:0] TYPE_YUV420_8C = 6'h1c;
  localparam logic [5:0] TYPE_YUV420_10C = 6'h1d;
  localparam logic [5:0] TYPE_YUV422_8 = 6'h1e;
  localparam logic [5:0] TYPE_YUV422_10 = 6'h1f;
  localparam logic [5:0] TYPE_RGB444 = 6'h20;
  localparam logic [5:0] TYPE_RGB555 = 6'h21;
  localparam logic [5:0] TYPE_RGB565 = 6'h22;
  localparam logic [5:0] TYPE_RGB666 = 6'h23;
  localparam logic [5:0] TYPE_RGB888 = 6'h24;
  localparam logic [5:0] TYPE_RAW6 = 6'h28;
  localparam logic [5:0] TYPE_RAW7 = 6'h29;
  localparam logic [5:0] TYPE_RAW8 = 6'h2a;
  localparam logic [5:0] TYPE_RAW10 = 6'h2b;
  localparam logic [5:0] TYPE_RAW12 = 6'h2c;
  localparam logic [5:0] TYPE_RAW14 = 6'h2d;
  localparam logic [2:0] TYPE_USER_HI = 3'h6;
  localparam logic [1:0] LP11 = 2'h3;
  localparam logic [1:0] LP01 = 2'h1;
  localparam logic [1:0] LP00 = 2'h0;

  typedef enum logic [2:0] {LN_IDLE, LN_STOP, LN_REQ, LN_PREP, LN_HS} crx_lane_st_t;

  function automatic int ui_ps(input int mbps);
    return 1000000 / mbps;
  endfunction

  // least times round up, longest round down, never below one cycle
  function automatic int min_cyc(input int ps);
    int c;
    c = (ps + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    return (c < 1) ? 1 : c;
  endfunction

  function automatic int max_cyc(input int ps);
    int c;
    c = ps / CLK_PERIOD_PS;
    return (c < 1) ? 1 : c;
  endfunction

  function automatic logic [3:0] fmt_ppc(input logic [5:0] t, input logic odd);
    case (t)
      TYPE_RGB444, TYPE_RGB555, TYPE_RGB565: return 4'h4;
      TYPE_RGB666: return 4'h3;
      TYPE_RGB888, TYPE_YUV422_10: return 4'h2;
      TYPE_RAW6, TYPE_RAW7, TYPE_RAW8: return 4'h8;
      TYPE_RAW10, TYPE_RAW12, TYPE_RAW14: return 4'h4;
      TYPE_YUV420_8, TYPE_YUV420_8C: return odd ? 4'h8 : 4'h4;
      TYPE_YUV420_10, TYPE_YUV420_10C: return odd ? 4'h4 : 4'h2;
      TYPE_YUV420_LEG, TYPE_YUV422_8: return 4'h4;
      default: return (t[5:3] == TYPE_USER_HI) ? 4'h8 : 4'h0;
    endcase
  endfunction

  function automatic logic [4:0] fmt_bpp(input logic [5:0] t, input logic odd);
    case (t)
      TYPE_RGB444, TYPE_RAW12, TYPE_YUV420_LEG: return 5'h0c;
      TYPE_RGB555: return 5'h0f;
      TYPE_RGB565, TYPE_YUV422_8: return 5'h10;
      TYPE_RGB666: return 5'h12;
      TYPE_RGB888: return 5'h18;
      TYPE_RAW6: return 5'h06;
      TYPE_RAW7: return 5'h07;
      TYPE_RAW8: return 5'h08;
      TYPE_RAW10: return 5'h0a;
      TYPE_RAW14: return 5'h0e;
      TYPE_YUV420_8, TYPE_YUV420_8C: return odd ? 5'h08 : 5'h10;
      TYPE_YUV420_10, TYPE_YUV420_10C: return odd ? 5'h0a : 5'h14;
      TYPE_YUV422_10: return 5'h14;
      default: return (t[5:3] == TYPE_USER_HI) ? 5'h08 : 5'h00;
    endcase
  endfunction
endpackage

// >>> verilog/crx_lane_timer.sv
// crx_lane_timer: low-power line-state tracker and settle timer for one lane.
// assumes raw line-state pins from outside the clock domain; settle time comes from fabric on clk.
`timescale 1ns/10ps
module crx_lane_timer import crx_pkg::*; #(
  parameter int SETTLE_MIN_CYC = 3,
  parameter int SETTLE_MAX_CYC = 7
) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // line-state pins
  input wire logic lp_p,
  input wire logic lp_n,
  // configured settle time in ns
  input wire logic [SETTLE_W-1:0] settle_ns,
  // lane may be listened to in high-speed mode
  output logic hs_accept
);
  logic p_s1, p_s2, n_s1, n_s2;
  logic [1:0] lp;
  crx_lane_st_t state;
  logic [CNT_W-1:0] cnt;
  logic [SETTLE_W-1:0] cfg_cyc;
  logic [CNT_W-1:0] settle_cyc;

  always_ff @(posedge clk) begin
    p_s1 <= lp_p;
    p_s2 <= p_s1;
    n_s1 <= lp_n;
    n_s2 <= n_s1;
  end
  assign lp = {p_s2, n_s2};

  // the configured window is clamped to what the lane may legally need
  always_comb begin
    cfg_cyc = SETTLE_W'((32'(settle_ns) + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    if (cfg_cyc < SETTLE_W'(SETTLE_MIN_CYC)) begin
      settle_cyc = CNT_W'(SETTLE_MIN_CYC);
    end else if (cfg_cyc > SETTLE_W'(SETTLE_MAX_CYC)) begin
      settle_cyc = CNT_W'(SETTLE_MAX_CYC);
    end else begin
      settle_cyc = CNT_W'(cfg_cyc);
    end
  end

  // high-speed swing reads as LP-00 on these pins, so only LP-11 ends the burst
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state <= LN_IDLE;
      hs_accept <= 1'b0;
    end else begin
      case (state)
        LN_IDLE: if (lp == LP11) state <= LN_STOP;
        LN_STOP: begin
          if (lp == LP01) state <= LN_REQ;
          else if (lp != LP11) state <= LN_IDLE;
        end
        LN_REQ: begin
          if (lp == LP00) state <= LN_PREP;
          else if (lp == LP11) state <= LN_STOP;
          else if (lp != LP01) state <= LN_IDLE;
        end
        LN_PREP: begin
          if (lp == LP11) begin
            state <= LN_STOP;
          end else if (lp != LP00) begin
            state <= LN_IDLE;
          end else if (cnt + CNT_W'(1) >= settle_cyc) begin
            state <= LN_HS;
            hs_accept <= 1'b1;
          end
        end
        LN_HS: begin
          if (lp == LP11) begin
            state <= LN_STOP;
            hs_accept <= 1'b0;
          end
        end
        default: begin
          state <= LN_IDLE;
          hs_accept <= 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst || state != LN_PREP) cnt <= '0;
    else cnt <= cnt + CNT_W'(1);
  end

  sequence s_hs_stop;
    (state == LN_HS) ##0 (lp == LP11);
  endsequence

  sequence s_req_prep;
    (state == LN_REQ) ##1 (state == LN_PREP);
  endsequence

  AST_PREP_FROM_REQ: assert property (@(posedge clk) disable iff (sys_rst)
    $rose(state == LN_PREP) |-> $past(state) == LN_REQ && $past(lp) == LP00)
    else $error("prep entered without request state");
  AST_REQ_FROM_STOP: assert property (@(posedge clk) disable iff (sys_rst)
    s_req_prep |-> $past(state, 2) == LN_STOP || $past(state, 2) == LN_REQ)
    else $error("request not preceded by stop state");
  AST_EXIT_STOP: assert property (@(posedge clk) disable iff (sys_rst)
    s_hs_stop |=> !hs_accept && state == LN_STOP)
    else $error("stop state did not end burst");
  AST_SETTLE_WIN: assert property (@(posedge clk) disable iff (sys_rst)
    $rose(hs_accept) |-> cnt == $past(settle_cyc) && cnt >= SETTLE_MIN_CYC && cnt <= SETTLE_MAX_CYC)
    else $error("settle window violated");
  AST_CFG_CLAMP: assert property (@(posedge clk) disable iff (sys_rst)
    settle_cyc >= CNT_W'(SETTLE_MIN_CYC) && settle_cyc <= CNT_W'(SETTLE_MAX_CYC))
    else $error("settle count outside clamp");
endmodule

// >>> verilog/crx_top.sv
// crx_top: camera link receiver, pixel packing onto a 64-bit bus and lane settle timing.
// assumes link logic on link_clk delivers one pixel per cycle and at least two link cycles per word.
// Notes on behaviour
// - format code changes only while hsync low
// - RGB codes pack 4,4,4,3,2 pixels
// - RAW 8 or 4 pixels; user codes 8
// - YUV420 odd/even pixel counts; YUV422 four, two
// - enter high speed via LP-11, LP-01, LP-00
// - LP-11 ends a high-speed burst
// - ignore clock lane for its settle time
// - data lane settle between both limits
// - settle timers configurable 40 to 2590 ns; code clamps clock lane to 120-280 ns, data lane to 120 ns at 800 Mbps
// - new pixel word presented per transfer
`timescale 1ns/10ps
module crx_top import crx_pkg::*; #(
  parameter int LANE_MBPS = DEF_LANE_MBPS
) (
  // system
  input wire logic clk,
  input wire logic sys_rst,
  // lane line-state pins
  input wire logic clk_lane_lp_p,
  input wire logic clk_lane_lp_n,
  input wire logic dat_lane_lp_p,
  input wire logic dat_lane_lp_n,
  // settle configuration, ns
  input wire logic [SETTLE_W-1:0] clock_lane_settle_time,
  input wire logic [SETTLE_W-1:0] data_lane_settle_time,
  // link-side pixel stream
  input wire logic link_clk,
  input wire logic link_line_active,
  input wire logic [TYPE_W-1:0] link_line_type,
  input wire logic link_pix_valid,
  input wire logic [PIX_W-1:0] link_pix_data,
  // pixel bus
  output logic [WORD_W-1:0] pixel_data,
  output logic pixel_valid,
  output logic [TYPE_W-1:0] pixel_type,
  output logic pixel_hsync,
  output logic pixel_odd_line,
  // lane status
  output logic clock_lane_hs,
  output logic data_lane_hs
);
  localparam int UI = ui_ps(LANE_MBPS);
  localparam int CK_MIN_CYC = min_cyc(CK_SETTLE_MIN_NS * 1000);
  localparam int CK_MAX_CYC = max_cyc(CK_SETTLE_MAX_NS * 1000);
  localparam int DL_MIN_CYC = min_cyc(DL_SETTLE_MIN_NS * 1000 + DL_SETTLE_MIN_UI * UI);
  localparam int DL_MAX_CYC_RAW = max_cyc(DL_SETTLE_MAX_NS * 1000 + DL_SETTLE_MAX_UI * UI);
  localparam int DL_MAX_CYC = (DL_MAX_CYC_RAW < DL_MIN_CYC) ? DL_MIN_CYC : DL_MAX_CYC_RAW;

  crx_lane_timer #(.SETTLE_MIN_CYC(CK_MIN_CYC), .SETTLE_MAX_CYC(CK_MAX_CYC)) u_ck_lane (
    .clk(clk),
    .sys_rst(sys_rst),
    .lp_p(clk_lane_lp_p),
    .lp_n(clk_lane_lp_n),
    .settle_ns(clock_lane_settle_time),
    .hs_accept(clock_lane_hs)
  );

  crx_lane_timer #(.SETTLE_MIN_CYC(DL_MIN_CYC), .SETTLE_MAX_CYC(DL_MAX_CYC)) u_dl_lane (
    .clk(clk),
    .sys_rst(sys_rst),
    .lp_p(dat_lane_lp_p),
    .lp_n(dat_lane_lp_n),
    .settle_ns(data_lane_settle_time),
    .hs_accept(data_lane_hs)
  );

  // data is only trusted while the clock lane is also running
  logic lane_ok;
  always_ff @(posedge clk) begin
    if (sys_rst) lane_ok <= 1'b0;
    else lane_ok <= clock_lane_hs && data_lane_hs;
  end

  // link domain reset and lane-ok level crossing
  logic rst_l1, link_rst, ok_s1, ok_s2;
  always_ff @(posedge link_clk) begin
    rst_l1 <= sys_rst;
    link_rst <= rst_l1;
  end
  always_ff @(posedge link_clk) begin
    ok_s1 <= lane_ok;
    ok_s2 <= ok_s1;
  end

  logic line_prev, line_odd, first_pend;
  logic [TYPE_W-1:0] cur_type;
  logic [2:0] idx;
  logic [WORD_W-1:0] acc, pix_word, xfer_word;
  logic [TYPE_W-1:0] xfer_type;
  logic xfer_first, xfer_odd, xfer_tgl;
  logic [3:0] ppc;
  logic [4:0] bpp;
  logic pix_take, word_done;

  always_comb begin
    ppc = fmt_ppc(cur_type, line_odd);
    bpp = fmt_bpp(cur_type, line_odd);
    pix_take = link_pix_valid && link_line_active && line_prev && ok_s2 && (ppc != 4'h0);
    word_done = pix_take && ({1'b0, idx} == ppc - 4'h1);
    pix_word = acc | (WORD_W'(link_pix_data & PIX_W'((32'h1 << bpp) - 32'h1)) << (8'(idx) * 8'(bpp)));
  end

  // format is sampled only between lines, so it is frozen for a whole line
  always_ff @(posedge link_clk) begin
    if (link_rst) begin
      line_prev <= 1'b0;
      line_odd <= 1'b0;
      cur_type <= TYPE_RST;
    end else begin
      line_prev <= link_line_active;
      if (!link_line_active) cur_type <= link_line_type;
      if (link_line_active && !line_prev) line_odd <= ~line_odd;
    end
  end

  // a partial word left at line end is dropped
  always_ff @(posedge link_clk) begin
    if (link_rst || !link_line_active || word_done) begin
      idx <= 3'h0;
      acc <= '0;
    end else if (pix_take) begin
      idx <= idx + 3'h1;
      acc <= pix_word;
    end
  end

  always_ff @(posedge link_clk) begin
    if (link_rst) begin
      xfer_tgl <= 1'b0;
      xfer_word <= '0;
      xfer_type <= TYPE_RST;
      xfer_first <= 1'b0;
      xfer_odd <= 1'b0;
      first_pend <= 1'b0;
    end else begin
      if (link_line_active && !line_prev) first_pend <= 1'b1;
      if (word_done) begin
        xfer_word <= pix_word;
        xfer_type <= cur_type;
        xfer_first <= first_pend;
        xfer_odd <= line_odd;
        xfer_tgl <= ~xfer_tgl;
        first_pend <= 1'b0;
      end
    end
  end

  // toggle crossing; the word registers stay still for two link cycles, longer than the sync delay
  logic t_s1, t_s2, t_s3, a_s1, a_s2, new_word;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      t_s1 <= 1'b0;
      t_s2 <= 1'b0;
      t_s3 <= 1'b0;
      a_s1 <= 1'b0;
      a_s2 <= 1'b0;
    end else begin
      t_s1 <= xfer_tgl;
      t_s2 <= t_s1;
      t_s3 <= t_s2;
      a_s1 <= link_line_active;
      a_s2 <= a_s1;
    end
  end
  assign new_word = t_s2 ^ t_s3;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pixel_data <= '0;
      pixel_valid <= 1'b0;
      pixel_odd_line <= 1'b0;
    end else begin
      pixel_valid <= new_word;
      if (new_word) begin
        pixel_data <= xfer_word;
        pixel_odd_line <= xfer_odd;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pixel_type <= TYPE_RST;
      pixel_hsync <= 1'b0;
    end else if (new_word && xfer_first && !pixel_hsync) begin
      pixel_type <= xfer_type;
      pixel_hsync <= 1'b1;
    end else if (!a_s2 && !new_word) begin
      pixel_hsync <= 1'b0;
    end
  end

  AST_TYPE_HOLD: assert property (@(posedge clk) disable iff (sys_rst)
    $past(pixel_hsync) |-> $stable(pixel_type))
    else $error("format code changed during active line");
  AST_WORD_OUT: assert property (@(posedge clk) disable iff (sys_rst)
    new_word |=> pixel_valid && pixel_data == $past(xfer_word))
    else $error("pixel word not presented");
  AST_RGB888_PACK: assert property (@(posedge link_clk) disable iff (link_rst)
    (pix_take && cur_type == TYPE_RGB888 && idx == 3'h1) |=> $changed(xfer_tgl) && xfer_word[63:48] == 16'h0000)
    else $error("rgb888 word not two pixels");
  AST_RGB666_HOLD: assert property (@(posedge link_clk) disable iff (link_rst)
    (pix_take && cur_type == TYPE_RGB666 && idx == 3'h1) |=> $stable(xfer_tgl))
    else $error("rgb666 word closed early");
  AST_RAW8_PACK: assert property (@(posedge link_clk) disable iff (link_rst)
    (pix_take && cur_type == TYPE_RAW8 && idx == 3'h7) |=> $changed(xfer_tgl)
      && xfer_word[63:56] == $past(link_pix_data[7:0]))
    else $error("raw8 word not eight pixels");
  AST_YUV_EVEN: assert property (@(posedge link_clk) disable iff (link_rst)
    (pix_take && cur_type == TYPE_YUV420_8 && !line_odd && idx == 3'h3) |=> $changed(xfer_tgl))
    else $error("yuv420 even line not four pixels");
endmodule

// >>> testbench/crx_tx_model.sv
// crx_tx_model: behavioural camera-side transmitter, lane line states and link pixel stream.
// assumes clk is the receiver clock; lane pins move on its falling edge, link clock runs only in lines.
`timescale 1ns/10ps
module crx_tx_model import crx_pkg::*; (
  // receiver clock
  input wire logic clk,
  // lane pins
  output logic clk_lane_lp_p,
  output logic clk_lane_lp_n,
  output logic dat_lane_lp_p,
  output logic dat_lane_lp_n,
  // link stream
  output logic link_clk,
  output logic link_line_active,
  output logic [TYPE_W-1:0] link_line_type,
  output logic link_pix_valid,
  output logic [PIX_W-1:0] link_pix_data
);
  initial begin
    {clk_lane_lp_p, clk_lane_lp_n, dat_lane_lp_p, dat_lane_lp_n} = 4'hf;
    link_clk = 1'b0;
    link_line_active = 1'b0;
    link_line_type = 6'h00;
    link_pix_valid = 1'b0;
    link_pix_data = 30'h0;
  end

  // three or more cycles keeps every low-power state well past 50 ns
  task automatic lp(input bit dl, input logic [1:0] st, input int n);
    @(negedge clk);
    if (dl) {dat_lane_lp_p, dat_lane_lp_n} = st;
    else {clk_lane_lp_p, clk_lane_lp_n} = st;
    repeat (n) @(negedge clk);
  endtask

  // lane stays at 00 once in high speed, since its low-power levels read as zero there
  task automatic enter(input bit dl);
    lp(dl, LP11, 3);
    lp(dl, LP01, 3);
    lp(dl, LP00, 0);
  endtask

  // a lane leaves high speed by holding LP-11 for four cycles, 160 ns
  task automatic leave(input bit dl);
    lp(dl, LP11, 4);
  endtask

  task automatic cyc(input int n);
    repeat (n) begin
      #40 link_clk = 1'b1;
      #40 link_clk = 1'b0;
    end
  endtask

  task automatic send_line(input logic [5:0] t, input int n);
    #7;
    link_line_type = t;
    cyc(1);
    link_line_active = 1'b1;
    cyc(1);
    for (int k = 0; k < n; k++) begin
      link_pix_valid = 1'b1;
      link_pix_data = 30'h1f3c5a96 + 30'(k * 'h246813);
      cyc(1);
    end
    link_pix_valid = 1'b0;
    link_pix_data = ~link_pix_data;
    link_line_active = 1'b0;
    cyc(5);
  endtask
endmodule

// >>> testbench/tb_crx_top.sv
// tb_crx_top: self-checking bench for the camera link receiver.
// assumes crx_tx_model plays the transmitter; lane rate left at its default.
`timescale 1ns/10ps
module tb_crx_top import crx_pkg::*;;
  // row: type, odd-line ppc and bpp, even-line ppc and bpp
  localparam logic [31:0] ROWS [21] = '{32'h2040c40c, 32'h2140f40f, 32'h22410410, 32'h23312312,
    32'h24218218, 32'h28806806, 32'h29807807, 32'h2a808808, 32'h2b40a40a, 32'h2c40c40c, 32'h2d40e40e,
    32'h18808410, 32'h1940a214, 32'h1a40c40c, 32'h1c808410, 32'h1d40a214, 32'h1e410410, 32'h1f214214,
    32'h30808808, 32'h33808808, 32'h37808808};
  localparam int SET_NS [3] = '{40, 200, 2590};
  localparam int SET_N [3] = '{3, 5, 7};
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [SETTLE_W-1:0] clock_lane_settle_time = 12'h0c8;
  logic [SETTLE_W-1:0] data_lane_settle_time = 12'h05a;
  logic clk_lane_lp_p, clk_lane_lp_n, dat_lane_lp_p, dat_lane_lp_n;
  logic link_clk, link_line_active, link_pix_valid;
  logic [TYPE_W-1:0] link_line_type;
  logic [PIX_W-1:0] link_pix_data;
  logic [WORD_W-1:0] pixel_data;
  logic [TYPE_W-1:0] pixel_type;
  logic pixel_valid, pixel_hsync, pixel_odd_line, clock_lane_hs, data_lane_hs;
  int errors = 0;
  int check_count = 0;
  int c;

  always #20 clk = ~clk;

  crx_tx_model crx_tx_model_i (.clk(clk), .clk_lane_lp_p(clk_lane_lp_p), .clk_lane_lp_n(clk_lane_lp_n),
    .dat_lane_lp_p(dat_lane_lp_p), .dat_lane_lp_n(dat_lane_lp_n), .link_clk(link_clk),
    .link_line_active(link_line_active), .link_line_type(link_line_type), .link_pix_valid(link_pix_valid),
    .link_pix_data(link_pix_data));

  crx_top crx_top_i (.clk(clk), .sys_rst(sys_rst), .clk_lane_lp_p(clk_lane_lp_p),
    .clk_lane_lp_n(clk_lane_lp_n), .dat_lane_lp_p(dat_lane_lp_p), .dat_lane_lp_n(dat_lane_lp_n),
    .clock_lane_settle_time(clock_lane_settle_time), .data_lane_settle_time(data_lane_settle_time),
    .link_clk(link_clk), .link_line_active(link_line_active), .link_line_type(link_line_type),
    .link_pix_valid(link_pix_valid), .link_pix_data(link_pix_data), .pixel_data(pixel_data),
    .pixel_valid(pixel_valid), .pixel_type(pixel_type), .pixel_hsync(pixel_hsync),
    .pixel_odd_line(pixel_odd_line), .clock_lane_hs(clock_lane_hs), .data_lane_hs(data_lane_hs));

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic stop_test();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic hs_wait(input bit dl, output int n);
    n = 0;
    while ((dl ? data_lane_hs : clock_lane_hs) !== 1'b1 && n < 20) begin
      @(negedge clk);
      n++;
    end
  endtask

  // the word pulse is one cycle wide, so sample it at the falling edge
  task automatic wait_word(output logic ok);
    ok = 1'b0;
    repeat (40) begin
      @(negedge clk);
      if (pixel_valid === 1'b1) begin
        ok = 1'b1;
        break;
      end
    end
  endtask

  // ppc of zero means the line must yield no word at all
  task automatic run_line(input logic [5:0] t, input int npix, ppc, bpp, input logic odd);
    logic ok;
    logic [63:0] exp;
    logic [29:0] p;
    fork
      crx_tx_model_i.send_line(t, npix);
      for (int w = 0; w < ((ppc != 0) ? npix / ppc : 1); w++) begin
        wait_word(ok);
        chk(ok, ppc != 0);
        if (ok) begin
          exp = '0;
          for (int i = 0; i < ppc; i++) begin
            p = 30'h1f3c5a96 + 30'((w * ppc + i) * 'h246813);
            for (int b = 0; b < bpp; b++) exp[i * bpp + b] = p[b];
          end
          chk(pixel_data, exp);
          chk({pixel_type, pixel_hsync, pixel_odd_line}, {t, 1'b1, odd});
        end
      end
    join
  endtask

  initial begin
    #300000;
    errors++;
    stop_test();
  end

  initial begin
    fork
      crx_tx_model_i.cyc(6);
      repeat (12) @(negedge clk);
    join
    sys_rst = 1'b0;
    @(negedge clk);
    chk(pixel_data, 64'h0);
    chk({pixel_valid, pixel_type, pixel_hsync, pixel_odd_line, clock_lane_hs, data_lane_hs}, 0);
    $display("reset test done");
    // the link reset only lets go on link clock edges, and that clock stands still between lines
    crx_tx_model_i.cyc(4);
    for (int r = 0; r < 3; r++) begin
      clock_lane_settle_time = 12'(SET_NS[r]);
      crx_tx_model_i.enter(1'b0);
      hs_wait(1'b0, c);
      chk(c >= SET_N[r] + 2 && c <= SET_N[r] + 4, 1'b1);
      crx_tx_model_i.leave(1'b0);
      chk(clock_lane_hs, 1'b0);
    end
    $display("clock lane test done");
    crx_tx_model_i.enter(1'b0);
    hs_wait(1'b0, c);
    // clock lane runs 320 ns before the data lane starts
    repeat (8) @(negedge clk);
    // longest legal setting; the data window is one count wide at this rate, so the clamp must hold it there
    data_lane_settle_time = 12'(SET_NS[2]);
    crx_tx_model_i.enter(1'b1);
    hs_wait(1'b1, c);
    chk(c >= 5 && c <= 7, 1'b1);
    $display("data lane test done");
    for (int r = 0; r < 21; r++) begin
      if (r % 2 == 0) run_line(ROWS[r][29:24], 2 * ROWS[r][23:20], ROWS[r][23:20], ROWS[r][19:12], 1'b1);
      else run_line(ROWS[r][29:24], 2 * ROWS[r][11:8], ROWS[r][11:8], ROWS[r][7:0], 1'b0);
    end
    $display("format table test done");
    run_line(6'h25, 8, 0, 0, 1'b0);
    run_line(TYPE_RAW8, 7, 0, 0, 1'b0);
    crx_tx_model_i.leave(1'b1);
    chk(data_lane_hs, 1'b0);
    run_line(TYPE_RAW8, 16, 0, 0, 1'b0);
    crx_tx_model_i.lp(1'b1, 2'h2, 3);
    crx_tx_model_i.lp(1'b1, LP00, 0);
    hs_wait(1'b1, c);
    chk(c, 20);
    crx_tx_model_i.lp(1'b1, LP11, 3);
    crx_tx_model_i.lp(1'b1, LP00, 0);
    hs_wait(1'b1, c);
    chk(c, 20);
    $display("refusal test done");
    stop_test();
  end
endmodule
